// [sleep_params.svh]
// Purpose: offsets, field positions, reset values and counts
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes: included by the sleep and oscillator gating block
//
// Operation
// - idle 0: stop cpu clock only
// - idle 1: stop cpu and system bus
// - idle 2: also stop peripheral bus clock
// - standby: stop cpu, buses, main clock
// - idle depth halts clocks despite masks
// - regulator normal in every idle level
// - wfi with deep select 0 enters idle
// - sleep after isr enters sleep on exit
// - unmasked interrupt wakes idle to active
// - standby keeps only requested or always-on
// - standby puts regulator and ram low-power
// - wfi with deep select 1 enters standby
// - asynchronous interrupt wakes from standby
// - after wake, priority mask picks isr
// - standby walk runs main clock only, no cpu or buses
// - on-request oscillator runs only when requested
// - keep-in-standby decides oscillator in standby
// - crystal mode bit selects pad usage
// - enable bit turns oscillator on
// - 32k control register field layout
// - lock bit blocks later 32k writes
// - delay_select_a code selects ultra-low-power cycle count
// - three 32k cycles before ready
`ifndef SLEEP_PARAMS_SVH
`define SLEEP_PARAMS_SVH

`define IDLE_CFG_OFS  8'h00
`define SYS_CTRL_OFS  8'h04
`define STATUS_OFS    8'h0C
`define MAIN_OSC_OFS  8'h10
`define OSC32K_OFS    8'h14
`define SBUS_MASK_OFS 8'h18
`define PBUS_MASK_OFS 8'h1C

`define MAIN_OSC_RST  16'h0080
`define OSC32K_RST    16'h0080
`define MAIN_OSC_WM   16'h00C6
`define OSC32K_WM     16'h17EE

`define B_LOCK        12
`define B_SU_HI       10
`define B_SU_LO       8
`define B_ONREQ       7
`define B_KEEP        6
`define B_AMP         5
`define B_OUT32       3
`define B_XTAL        2
`define B_EN          1
`define B_SLP_ISR     1
`define B_DEEP        2

`define SU_CYC_0      18'h00001
`define SU_CYC_1      18'h00020
`define SU_CYC_2      18'h00800
`define SU_CYC_3      18'h01000
`define SU_CYC_4      18'h04000
`define SU_CYC_5      18'h08000
`define SU_CYC_6      18'h10000
`define SU_CYC_7      18'h20000
`define SYNC_LAST     2'h2

`endif

// [sleep_pkg.sv]
// Purpose: shared types of the sleep and oscillator gating block
// Assumes: nothing
// Notes: one-hot power states
package sleep_pkg;

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_IDLE   = 4'h2,
    ST_STBY   = 4'h4,
    ST_WALK   = 4'h8
  } pm_state_t;

  typedef struct packed {
    logic cpu;
    logic sys_bus;
    logic periph_bus;
    logic main;
  } clk_gate_t;

  typedef struct packed {
    logic regulator_lp;
    logic ram_lp;
  } power_mode_t;

  typedef struct packed {
    logic main_osc;
    logic osc_32k;
  } osc_req_t;

endpackage

// [sleep_osc_gating.sv]
// Purpose: sleep mode sequencing and oscillator gating
// Assumes: all inputs synchronous to sys_clk; ticks are 1-cycle pulses
// Notes: one wait state on every bus access
`include "sleep_params.svh"
`timescale 1ns/10ps
`default_nettype none

module sleep_osc_gating #(
  parameter int MASK_W = 8
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   wfi_exec,
  input  wire logic                   isr_exit_lowest,
  input  wire logic                   irq_wake,
  input  wire logic                   async_irq,
  input  wire logic                   irq_priority_mask,
  input  wire logic                   sleepwalk_req,
  input  wire sleep_pkg::osc_req_t    osc_req,
  input  wire logic                   ulp_32k_tick,
  input  wire logic                   ext_32k_tick,
  output sleep_pkg::clk_gate_t        clk_gate,
  output logic [MASK_W-1:0]           sys_bus_clk_en,
  output logic [MASK_W-1:0]           periph_bus_clk_en,
  output sleep_pkg::power_mode_t      power_mode,
  output sleep_pkg::osc_req_t         osc_run,
  output logic                        main_xtal_mode,
  output logic                        osc32k_xtal_mode,
  output logic                        osc32k_amp_ctrl,
  output logic                        osc32k_out_en,
  output logic                        osc32k_ready,
  output logic                        wake_pulse,
  output logic                        wake_take_isr
);
  import sleep_pkg::*;

  pm_state_t         state_ff;
  pm_state_t         nxt_state;
  logic              wake_ff;
  logic              nxt_wake;
  logic              isr_ff;
  logic              nxt_isr;
  logic [1:0]        idle_depth_ff;
  logic [1:0]        nxt_idle_depth;
  logic              sleep_isr_ff;
  logic              nxt_sleep_isr;
  logic              deep_ff;
  logic              nxt_deep;
  logic [15:0]       main_cfg_ff;
  logic [15:0]       nxt_main_cfg;
  logic [15:0]       x32_cfg_ff;
  logic [15:0]       nxt_x32_cfg;
  logic [MASK_W-1:0] sbus_mask_ff;
  logic [MASK_W-1:0] nxt_sbus_mask;
  logic [MASK_W-1:0] pbus_mask_ff;
  logic [MASK_W-1:0] nxt_pbus_mask;
  logic              ack_ff;
  logic              nxt_ack;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [17:0]       su_cnt_ff;
  logic [17:0]       nxt_su_cnt;
  logic [1:0]        sync_ff;
  logic [1:0]        nxt_sync;
  logic              rdy32_ff;
  logic              nxt_rdy32;
  logic              main_rdy_ff;
  logic              nxt_main_rdy;
  logic              wr_go;
  logic              sleep_go;
  logic              in_idle;
  logic              in_stby;
  logic [17:0]       su_target;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [15:0] wm);
    logic [15:0] m;
    m = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    merge16 = m & wm;
  endfunction

  // oscillator run decision shared by both sources
  function automatic logic osc_on(input logic [15:0] cfg,
                                  input logic        req,
                                  input logic        stby);
    logic want;
    want = !cfg[`B_ONREQ] || req;
    osc_on = cfg[`B_EN] && want && (!stby || cfg[`B_KEEP]);
  endfunction

  function automatic logic [17:0] su_cycles(input logic [2:0] code);
    case (code)
      3'h0: su_cycles = `SU_CYC_0;
      3'h1: su_cycles = `SU_CYC_1;
      3'h2: su_cycles = `SU_CYC_2;
      3'h3: su_cycles = `SU_CYC_3;
      3'h4: su_cycles = `SU_CYC_4;
      3'h5: su_cycles = `SU_CYC_5;
      3'h6: su_cycles = `SU_CYC_6;
      default: su_cycles = `SU_CYC_7;
    endcase
  endfunction

  // bus slave: first cycle waits, second completes
  assign wr_go           = avs_write && ack_ff;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign avs_readdata    = rdata_ff;

  always_comb begin
    nxt_ack   = (avs_read || avs_write) && !ack_ff;
    nxt_rdata = rdata_ff;
    if (avs_read && !ack_ff) begin
      nxt_rdata = 32'h0000_0000;
      case (avs_address)
        `IDLE_CFG_OFS:  nxt_rdata[1:0] = idle_depth_ff;
        `SYS_CTRL_OFS: begin
          nxt_rdata[`B_SLP_ISR] = sleep_isr_ff;
          nxt_rdata[`B_DEEP]    = deep_ff;
        end
        `STATUS_OFS:    nxt_rdata[5:0] = {state_ff, rdy32_ff, main_rdy_ff};
        `MAIN_OSC_OFS:  nxt_rdata[15:0] = main_cfg_ff;
        `OSC32K_OFS:    nxt_rdata[15:0] = x32_cfg_ff;
        `SBUS_MASK_OFS: nxt_rdata[MASK_W-1:0] = sbus_mask_ff;
        `PBUS_MASK_OFS: nxt_rdata[MASK_W-1:0] = pbus_mask_ff;
        default:        nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // software-visible configuration
  always_comb begin
    nxt_idle_depth = idle_depth_ff;
    nxt_sleep_isr  = sleep_isr_ff;
    nxt_deep       = deep_ff;
    nxt_main_cfg   = main_cfg_ff;
    nxt_x32_cfg    = x32_cfg_ff;
    nxt_sbus_mask  = sbus_mask_ff;
    nxt_pbus_mask  = pbus_mask_ff;
    if (wr_go && avs_byteenable[0]) begin
      case (avs_address)
        `IDLE_CFG_OFS:  nxt_idle_depth = avs_writedata[1:0];
        `SYS_CTRL_OFS: begin
          nxt_sleep_isr = avs_writedata[`B_SLP_ISR];
          nxt_deep      = avs_writedata[`B_DEEP];
        end
        `SBUS_MASK_OFS: nxt_sbus_mask = avs_writedata[MASK_W-1:0];
        `PBUS_MASK_OFS: nxt_pbus_mask = avs_writedata[MASK_W-1:0];
        default:        nxt_deep = deep_ff;
      endcase
    end
    if (wr_go && avs_address == `MAIN_OSC_OFS) begin
      nxt_main_cfg = merge16(main_cfg_ff, avs_writedata, avs_byteenable,
                             `MAIN_OSC_WM);
    end
    if (wr_go && avs_address == `OSC32K_OFS && !x32_cfg_ff[`B_LOCK]) begin
      nxt_x32_cfg = merge16(x32_cfg_ff, avs_writedata, avs_byteenable,
                            `OSC32K_WM);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_depth_ff <= 2'h0;
      sleep_isr_ff  <= 1'b0;
      deep_ff       <= 1'b0;
      main_cfg_ff   <= `MAIN_OSC_RST;
      x32_cfg_ff    <= `OSC32K_RST;
      sbus_mask_ff  <= '1;
      pbus_mask_ff  <= '1;
    end else begin
      idle_depth_ff <= nxt_idle_depth;
      sleep_isr_ff  <= nxt_sleep_isr;
      deep_ff       <= nxt_deep;
      main_cfg_ff   <= nxt_main_cfg;
      x32_cfg_ff    <= nxt_x32_cfg;
      sbus_mask_ff  <= nxt_sbus_mask;
      pbus_mask_ff  <= nxt_pbus_mask;
    end
  end

  // power state sequencing
  assign sleep_go = wfi_exec || (isr_exit_lowest && sleep_isr_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_wake  = 1'b0;
    unique case (state_ff)
      ST_ACTIVE: begin
        if (sleep_go) begin
          nxt_state = deep_ff ? ST_STBY : ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_wake || async_irq) begin
          nxt_state = ST_ACTIVE;
          nxt_wake  = 1'b1;
        end
      end
      ST_STBY: begin
        if (async_irq) begin
          nxt_state = ST_ACTIVE;
          nxt_wake  = 1'b1;
        end else if (sleepwalk_req) begin
          nxt_state = ST_WALK;
        end
      end
      ST_WALK: begin
        if (async_irq) begin
          nxt_state = ST_ACTIVE;
          nxt_wake  = 1'b1;
        end else if (!sleepwalk_req) begin
          nxt_state = ST_STBY;
        end
      end
    endcase
    nxt_isr = nxt_wake && !irq_priority_mask;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_ACTIVE;
      wake_ff  <= 1'b0;
      isr_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wake_ff  <= nxt_wake;
      isr_ff   <= nxt_isr;
    end
  end

  assign wake_pulse    = wake_ff;
  assign wake_take_isr = isr_ff;

  // clock and power gating
  assign in_idle = (state_ff == ST_IDLE);
  assign in_stby = (state_ff == ST_STBY) || (state_ff == ST_WALK);

  always_comb begin
    clk_gate.cpu        = (state_ff == ST_ACTIVE);
    clk_gate.sys_bus    = clk_gate.cpu
                          || (in_idle && idle_depth_ff == 2'h0);
    clk_gate.periph_bus = clk_gate.cpu
                          || (in_idle && idle_depth_ff < 2'h2);
    clk_gate.main       = (state_ff != ST_STBY);
    // halted bus clocks ignore the masks
    sys_bus_clk_en      = sbus_mask_ff & {MASK_W{clk_gate.sys_bus}};
    periph_bus_clk_en   = pbus_mask_ff & {MASK_W{clk_gate.periph_bus}};
    power_mode.regulator_lp = (state_ff == ST_STBY);
    power_mode.ram_lp       = (state_ff == ST_STBY);
    osc_run.main_osc = osc_on(main_cfg_ff, osc_req.main_osc,
                              in_stby);
    osc_run.osc_32k  = osc_on(x32_cfg_ff, osc_req.osc_32k,
                              in_stby);
  end

  assign main_xtal_mode   = main_cfg_ff[`B_XTAL];
  assign osc32k_xtal_mode = x32_cfg_ff[`B_XTAL];
  assign osc32k_amp_ctrl  = x32_cfg_ff[`B_AMP];
  assign osc32k_out_en    = x32_cfg_ff[`B_OUT32] && osc_run.osc_32k;
  assign osc32k_ready     = rdy32_ff;

  // 32k start-up: ultra-low-power ticks, then 3 crystal ticks
  assign su_target = su_cycles(x32_cfg_ff[`B_SU_HI:`B_SU_LO]);

  always_comb begin
    nxt_su_cnt   = su_cnt_ff;
    nxt_sync     = sync_ff;
    nxt_rdy32    = rdy32_ff;
    nxt_main_rdy = osc_run.main_osc;
    if (!osc_run.osc_32k) begin
      nxt_su_cnt = 18'h00000;
      nxt_sync   = 2'h0;
      nxt_rdy32  = 1'b0;
    end else if (su_cnt_ff < su_target) begin
      if (ulp_32k_tick) begin
        nxt_su_cnt = su_cnt_ff + 18'h00001;
      end
    end else if (!rdy32_ff && ext_32k_tick) begin
      if (sync_ff == `SYNC_LAST) begin
        nxt_rdy32 = 1'b1;
      end else begin
        nxt_sync = sync_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      su_cnt_ff   <= 18'h00000;
      sync_ff     <= 2'h0;
      rdy32_ff    <= 1'b0;
      main_rdy_ff <= 1'b0;
    end else begin
      su_cnt_ff   <= nxt_su_cnt;
      sync_ff     <= nxt_sync;
      rdy32_ff    <= nxt_rdy32;
      main_rdy_ff <= nxt_main_rdy;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  idle0_gates_a: assert property (
    in_idle && idle_depth_ff == 2'h0 |-> !clk_gate.cpu
      && clk_gate.sys_bus && clk_gate.periph_bus && clk_gate.main
      && !power_mode.regulator_lp)
    else $error("idle 0 clock gating wrong");

  idle1_gates_a: assert property (
    in_idle && idle_depth_ff == 2'h1 |-> !clk_gate.sys_bus
      && clk_gate.periph_bus && clk_gate.main)
    else $error("idle 1 clock gating wrong");

  idle2_gates_a: assert property (
    in_idle && idle_depth_ff == 2'h2 |-> !clk_gate.periph_bus
      && sys_bus_clk_en == '0 && clk_gate.main)
    else $error("idle 2 clock gating wrong");

  stby_power_a: assert property (
    state_ff == ST_STBY |-> !clk_gate.main && !clk_gate.cpu
      && power_mode.regulator_lp && power_mode.ram_lp)
    else $error("standby power mode wrong");

  idle_entry_a: assert property (
    state_ff == ST_ACTIVE && wfi_exec && !deep_ff |=> in_idle
      ##1 (in_idle || wake_pulse))
    else $error("wfi did not enter idle");

  stby_entry_a: assert property (
    state_ff == ST_ACTIVE && wfi_exec && deep_ff |=> in_stby)
    else $error("wfi did not enter standby");

  exit_sleep_a: assert property (
    state_ff == ST_ACTIVE && isr_exit_lowest && sleep_isr_ff
      |=> !clk_gate.cpu)
    else $error("sleep on isr exit missed");

  idle_wake_a: assert property (
    in_idle && irq_wake |=> clk_gate.cpu && wake_pulse)
    else $error("idle wake missed");

  stby_wake_a: assert property (
    in_stby && async_irq |=> clk_gate.cpu
      && wake_take_isr == !$past(irq_priority_mask))
    else $error("standby wake wrong");

  lock_hold_a: assert property (
    x32_cfg_ff[`B_LOCK] |=> $stable(x32_cfg_ff))
    else $error("locked 32k register changed");

  ready_drop_a: assert property (
    !osc_run.osc_32k |=> !osc32k_ready)
    else $error("ready while 32k stopped");

  run_on_request_a: assert property (
    x32_cfg_ff[`B_ONREQ] && !osc_req.osc_32k |-> !osc_run.osc_32k)
    else $error("on-request oscillator ran");

  ready_rise_a: assert property (
    $rose(osc32k_ready) |-> $past(ext_32k_tick)
      && $past(sync_ff) == `SYNC_LAST)
    else $error("ready rose without sync");

endmodule

`default_nettype wire

// [osc_far_model.sv]
// Purpose: far side oscillators feeding the gating block tick pulses
// Assumes: ticks interleave, slow 32k at phase 0, crystal at phase 4
// Notes: counters report ticks seen while the 32k oscillator is on
`timescale 1ns/10ps
`default_nettype none

module osc_far_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       osc_32k_on,
  output logic            ulp_32k_tick,
  output logic            ext_32k_tick,
  output logic [7:0]      ulp_cnt_ff,
  output logic [7:0]      ext_cnt_ff
);
  logic [2:0] phase_ff;

  // slow reference runs free and clocks the start-up count
  assign ulp_32k_tick = (phase_ff == 3'h0);
  // a crystal gives edges only while it is enabled
  assign ext_32k_tick = osc_32k_on && (phase_ff == 3'h4);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_ff   <= 3'h0;
      ulp_cnt_ff <= 8'h00;
      ext_cnt_ff <= 8'h00;
    end else begin
      phase_ff <= phase_ff + 3'h1;
      if (!osc_32k_on) begin
        ulp_cnt_ff <= 8'h00;
        ext_cnt_ff <= 8'h00;
      end else begin
        if (ulp_32k_tick) ulp_cnt_ff <= ulp_cnt_ff + 8'h01;
        if (ext_32k_tick) ext_cnt_ff <= ext_cnt_ff + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// [tb_sleep_osc_gating.sv]
// Purpose: self-checking bench of the sleep and oscillator gating block
// Assumes: one wait state per bus access, MASK_W of 8
// Notes: sleep levels from a table, oscillators hand-written after it
`timescale 1ns/10ps
`default_nettype none

module tb_sleep_osc_gating;
  import sleep_pkg::*;
  typedef struct packed {
    logic       isr;
    logic       deep;
    logic [1:0] depth;
    logic       mask;
    logic [3:0] gate;
    logic [1:0] pm;
  } row_t;

  logic sys_clk = 1'b0, rst_b = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'hF;
  logic avs_waitrequest, wfi_exec = 1'b0, isr_exit_lowest = 1'b0;
  logic irq_wake = 1'b0, async_irq = 1'b0, irq_priority_mask = 1'b0;
  logic sleepwalk_req = 1'b0, ulp_32k_tick, ext_32k_tick;
  osc_req_t osc_req = '0, osc_run;
  clk_gate_t clk_gate;
  power_mode_t power_mode;
  logic [7:0] sys_bus_clk_en, periph_bus_clk_en, ulp_cnt, ext_cnt;
  logic main_xtal_mode, osc32k_xtal_mode, osc32k_amp_ctrl, osc32k_out_en;
  logic osc32k_ready, wake_pulse, wake_take_isr, last_isr = 1'b0;
  int fails = 0, tests_run = 0, cyc = 0, wake_cnt = 0, w0, n, mark;
  row_t rows [6] = '{
    '{1'b0, 1'b0, 2'h0, 1'b0, 4'b0111, 2'b00},
    '{1'b0, 1'b0, 2'h1, 1'b1, 4'b0011, 2'b00},
    '{1'b0, 1'b0, 2'h2, 1'b0, 4'b0001, 2'b00},
    '{1'b1, 1'b0, 2'h3, 1'b1, 4'b0001, 2'b00},
    '{1'b0, 1'b1, 2'h0, 1'b0, 4'b0000, 2'b11},
    '{1'b1, 1'b1, 2'h2, 1'b1, 4'b0000, 2'b11}};

  sleep_osc_gating i_sleep_osc_gating (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wfi_exec(wfi_exec), .isr_exit_lowest(isr_exit_lowest),
    .irq_wake(irq_wake), .async_irq(async_irq),
    .irq_priority_mask(irq_priority_mask), .sleepwalk_req(sleepwalk_req),
    .osc_req(osc_req), .ulp_32k_tick(ulp_32k_tick),
    .ext_32k_tick(ext_32k_tick), .clk_gate(clk_gate),
    .sys_bus_clk_en(sys_bus_clk_en), .periph_bus_clk_en(periph_bus_clk_en),
    .power_mode(power_mode), .osc_run(osc_run),
    .main_xtal_mode(main_xtal_mode), .osc32k_xtal_mode(osc32k_xtal_mode),
    .osc32k_amp_ctrl(osc32k_amp_ctrl), .osc32k_out_en(osc32k_out_en),
    .osc32k_ready(osc32k_ready), .wake_pulse(wake_pulse),
    .wake_take_isr(wake_take_isr));
  osc_far_model i_osc_far_model (.sys_clk(sys_clk), .rst_b(rst_b),
    .osc_32k_on(osc_run.osc_32k), .ulp_32k_tick(ulp_32k_tick),
    .ext_32k_tick(ext_32k_tick), .ulp_cnt_ff(ulp_cnt), .ext_cnt_ff(ext_cnt));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (wake_pulse === 1'b1) begin
      wake_cnt <= wake_cnt + 1;
      last_isr <= wake_take_isr;
    end
    if (cyc == 6000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    // wait ends when avs_waitrequest drops; the bench timeout ends a hang
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic pulse(input logic isr);
    if (isr) isr_exit_lowest <= 1'b1;
    else wfi_exec <= 1'b1;
    @(posedge sys_clk);
    isr_exit_lowest <= 1'b0;
    wfi_exec        <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wake(input logic asy);
    w0 = wake_cnt;
    if (asy) async_irq <= 1'b1;
    else irq_wake <= 1'b1;
    repeat (3) @(posedge sys_clk);
    async_irq <= 1'b0;
    irq_wake  <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({28'h0, clk_gate}, 32'hF);
    chk(wake_cnt - w0, 32'h1);
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    chk({24'h0, clk_gate, power_mode, osc_run}, 32'h0000_00F0);
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h80);
    bus(1'b0, 8'h10, 32'h0);
    chk(q, 32'h80);
    bus(1'b1, 8'h08, 32'hFFFF_FFFF);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, {30'h0, rows[i].depth});
      bus(1'b1, 8'h04, {29'h0, rows[i].deep, rows[i].isr, 1'b0});
      irq_priority_mask <= rows[i].mask;
      pulse(rows[i].isr);
      chk({28'h0, clk_gate}, {28'h0, rows[i].gate});
      chk({30'h0, power_mode}, {30'h0, rows[i].pm});
      chk({24'h0, sys_bus_clk_en}, {24'h0, {8{rows[i].gate[2]}}});
      chk({24'h0, periph_bus_clk_en}, {24'h0, {8{rows[i].gate[1]}}});
      bus(1'b0, 8'h0C, 32'h0);
      chk({28'h0, q[5:2]}, rows[i].deep ? 32'h4 : 32'h2);
      wake(rows[i].deep);
      chk({31'h0, last_isr}, {31'h0, !rows[i].mask});
    end
    // standby: oscillator off without keep, sync irq refused, walk
    bus(1'b1, 8'h10, 32'h2);
    chk({31'h0, osc_run.main_osc}, 32'h1);
    pulse(1'b0);
    chk({31'h0, osc_run.main_osc}, 32'h0);
    irq_wake <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({28'h0, clk_gate}, 32'h0);
    irq_wake      <= 1'b0;
    sleepwalk_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({28'h0, clk_gate}, 32'h1);
    sleepwalk_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({28'h0, clk_gate}, 32'h0);
    wake(1'b1);
    bus(1'b1, 8'h10, 32'h42);
    pulse(1'b0);
    chk({31'h0, osc_run.main_osc}, 32'h1);
    wake(1'b1);
    bus(1'b1, 8'h10, 32'hC2);
    chk({31'h0, osc_run.main_osc}, 32'h0);
    osc_req.main_osc <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, osc_run.main_osc}, 32'h1);
    bus(1'b1, 8'h10, 32'hC4);
    chk({30'h0, main_xtal_mode, osc_run.main_osc}, 32'h2);
    // 32k start-up with code 1, then on-request and lock
    bus(1'b1, 8'h14, 32'h012E);
    chk({29'h0, osc32k_xtal_mode, osc32k_amp_ctrl, osc32k_out_en}, 32'h7);
    n = 0;
    mark = -1;
    while (osc32k_ready !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
      if (mark < 0 && ulp_cnt >= 8'd32) mark = ext_cnt;
    end
    chk({31'h0, osc32k_ready}, 32'h1);
    // 32 start-up ticks, then two more fall inside the 3-tick sync
    chk({24'h0, ulp_cnt}, 32'h0000_0022);
    chk(ext_cnt - mark, 32'h3);
    bus(1'b1, 8'h14, 32'h01AE);
    @(posedge sys_clk);
    chk({30'h0, osc_run.osc_32k, osc32k_ready}, 32'h0);
    osc_req.osc_32k <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, osc_run.osc_32k}, 32'h1);
    bus(1'b1, 8'h14, 32'h112E);
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h112E);
    results();
  end
endmodule

`default_nettype wire
